// >>> hdl/fuse_config_loader.sv
// fuse configuration loader with apb read-back
`timescale 1ns/1ns
`include "fuse_config_loader_regs.svh"

module fuse_config_loader
  import fuse_config_pkg::*;
(
  // clock and reset
  input  wire logic           clk,
  input  wire logic           sys_rst,
  input  wire logic           power_on_reset,
  // apb slave
  input  wire logic           psel,
  input  wire logic           penable,
  input  wire logic           pwrite,
  input  wire logic [7:0]     paddr,
  input  wire logic [31:0]    pwdata,
  output logic      [31:0]    prdata,
  output logic                pready,
  output logic                pslverr,
  // fuse storage
  output logic                fuse_rd_en,
  output logic      [3:0]     fuse_rd_addr,
  input  wire logic [7:0]     fuse_rd_data,
  input  wire factory_cal_t   factory_cal,
  // crc unit
  output logic                crc_boot_req,
  output logic                crc_app_req,
  input  wire logic           crc_done,
  input  wire logic           crc_ok,
  // targets
  output watchdog_ctrl_t      watchdog_control_a,
  output brownout_ctrl_t      brownout_control,
  output osc_ctrl_t           osc_calibration,
  output timer_fault_t        timer_fault_control,
  output sys_ctrl_t           system_control,
  output logic                reset_released,
  // debug and erase
  input  wire logic           debug_entry,
  input  wire logic           fault_detect_flag,
  output logic                compare_force,
  output logic                flash_erase,
  output logic                eeprom_erase
);

  typedef struct packed {
    phase_t                     phase;
    logic [3:0]                 idx;
    logic [10:0][7:0]           fuse;
    watchdog_ctrl_t             wdt;
    brownout_ctrl_t             bod;
    osc_ctrl_t                  osc;
    timer_fault_t               tmr;
    sys_ctrl_t                  sys;
    logic                       por_seen;
    logic                       released;
    logic                       failed;
    logic                       boot_chk;
    logic                       app_chk;
    logic                       boot_req;
    logic                       app_req;
    logic                       rd_en;
    logic [3:0]                 rd_addr;
    logic                       ready;
    logic                       slverr;
    logic [31:0]                rdata;
    logic                       force_cmp;
    logic                       erase_flash;
    logic                       erase_eeprom;
  } loader_t;

  loader_t    st_reg;
  loader_t    st_next;
  logic [3:0] bus_idx;
  logic       bus_hit;
  logic [7:0] status_byte;
  logic       locked;
  logic [7:0] wdt_f;
  logic [7:0] bod_f;
  logic [7:0] osc_f;
  logic [7:0] tmr_f;
  logic [7:0] cfg0_f;

  ////////////////////////////////////////////////////////////////////////////
  // decode helpers

  assign bus_idx = paddr[`APB_IDX];
  assign bus_hit = (paddr[`APB_TOP] == 2'h0) && (paddr[`APB_LANE] == 2'h0)
                   && (bus_idx <= `IDX_ERASE_CONTROL);
  assign locked  = st_reg.fuse[`IDX_DEVICE_LOCK] != `LOCK_OPEN;
  assign wdt_f   = st_reg.fuse[`IDX_WATCHDOG];
  assign bod_f   = st_reg.fuse[`IDX_BROWNOUT];
  assign osc_f   = st_reg.fuse[`IDX_OSCILLATOR];
  assign tmr_f   = st_reg.fuse[`IDX_TIMER_FAULT];
  assign cfg0_f  = st_reg.fuse[`IDX_SYSTEM_CFG0];

  always_comb begin
    status_byte                  = 8'h00;
    status_byte[`STAT_RELEASED]  = st_reg.released;
    status_byte[`STAT_FAILED]    = st_reg.failed;
    status_byte[`STAT_POR]       = st_reg.por_seen;
    status_byte[`STAT_OSC16]     = st_reg.osc.run_16mhz;
    status_byte[`STAT_FREQ_RSV]  = (osc_f[`OSC_FREQ] != `FREQ_16MHZ)
                                   && (osc_f[`OSC_FREQ] != `FREQ_20MHZ);
    status_byte[`STAT_SLEEP_RSV] = st_reg.bod.sleep_mode == `SLEEP_RESERVED;
    status_byte[`STAT_BOOT_CHK]  = st_reg.boot_chk;
    status_byte[`STAT_APP_CHK]   = st_reg.app_chk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    st_next              = st_reg;
    st_next.rd_en        = 1'b0;
    st_next.ready        = 1'b0;
    st_next.slverr       = 1'b0;
    st_next.rdata        = 32'h0000_0000;
    st_next.force_cmp    = 1'b0;
    st_next.erase_flash  = 1'b0;
    st_next.erase_eeprom = 1'b0;

    case (st_reg.phase)
      ST_HOLD: begin
        st_next.idx   = `IDX_FIRST_FUSE;
        st_next.phase = ST_READ;
      end
      ST_READ: begin
        st_next.rd_en   = 1'b1;
        st_next.rd_addr = st_reg.idx;
        st_next.phase   = ST_CAPT;
      end
      ST_CAPT: begin
        st_next.fuse[st_reg.idx] = fuse_rd_data;
        if (st_reg.idx == `IDX_LAST_FUSE) begin
          st_next.phase = ST_APPLY;
        end else begin
          st_next.idx   = st_reg.idx + 4'h1;
          st_next.phase = ST_READ;
        end
      end
      ST_APPLY: begin
        // targets take the fuse image only here, once per reset
        st_next.wdt.window       = wdt_f[`WDT_WINDOW];
        st_next.wdt.period       = wdt_f[`WDT_PERIOD];
        st_next.bod.threshold    = bod_f[`BOD_LEVEL];
        st_next.bod.sample_rate  = bod_f[`BOD_SAMPLE];
        st_next.bod.active_mode  = bod_f[`BOD_ACTIVE];
        st_next.bod.sleep_mode   = bod_f[`BOD_SLEEP];
        st_next.osc.lock         = osc_f[`OSC_LOCK];
        if (osc_f[`OSC_FREQ] == `FREQ_16MHZ) begin
          st_next.osc.run_16mhz = 1'b1;
          st_next.osc.trim      = factory_cal.trim16;
          st_next.osc.temp_trim = factory_cal.temp16;
        end else begin
          st_next.osc.run_16mhz = 1'b0;
          st_next.osc.trim      = factory_cal.trim20;
          st_next.osc.temp_trim = factory_cal.temp20;
        end
        if (st_reg.por_seen) begin
          st_next.tmr.output_enable = tmr_f[`TMR_ENABLE];
          st_next.tmr.default_level = tmr_f[`TMR_LEVEL];
        end
        st_next.sys.reset_pin_function = cfg0_f[`CFG0_RST_PIN];
        st_next.sys.eeprom_preserve    = cfg0_f[`CFG0_EE_SAVE];
        st_next.sys.boot_check_disable = cfg0_f[`CFG0_BOOT_DIS];
        st_next.sys.app_check_disable  = cfg0_f[`CFG0_APP_DIS];
        st_next.phase                  = ST_CHECK;
      end
      ST_CHECK: begin
        st_next.boot_req = !st_reg.sys.boot_check_disable;
        st_next.app_req  = !st_reg.sys.app_check_disable;
        st_next.boot_chk = !st_reg.sys.boot_check_disable;
        st_next.app_chk  = !st_reg.sys.app_check_disable;
        if (st_reg.sys.boot_check_disable && st_reg.sys.app_check_disable) begin
          st_next.released = 1'b1;
          st_next.phase    = ST_RUN;
        end else begin
          st_next.phase = ST_WAIT;
        end
      end
      ST_WAIT: begin
        // reset stays held until the crc unit reports
        if (crc_done) begin
          st_next.boot_req = 1'b0;
          st_next.app_req  = 1'b0;
          if (crc_ok) begin
            st_next.released = 1'b1;
            st_next.phase    = ST_RUN;
          end else begin
            st_next.failed = 1'b1;
            st_next.phase  = ST_FAIL;
          end
        end
      end
      ST_RUN: begin
        st_next.force_cmp = debug_entry && fault_detect_flag;
      end
      ST_FAIL: begin
        st_next.phase = ST_FAIL;
      end
      default: begin
        st_next.phase = ST_HOLD;
      end
    endcase

    // apb: one wait state, answer one cycle after the access phase opens
    if (psel && penable && !st_reg.ready) begin
      st_next.ready  = 1'b1;
      st_next.slverr = !bus_hit;
      if (bus_hit && !pwrite) begin
        if (bus_idx <= `IDX_LAST_FUSE) begin
          st_next.rdata = {24'h00_0000, st_reg.fuse[bus_idx]};
        end else if (bus_idx == `IDX_LOADER_STATUS) begin
          st_next.rdata = {24'h00_0000, status_byte};
        end else begin
          st_next.rdata = 32'h0000_0000;
        end
      end
      if (bus_hit && pwrite && (bus_idx == `IDX_ERASE_CONTROL)
          && pwdata[`ERASE_GO_BIT] && (st_reg.phase == ST_RUN)) begin
        st_next.erase_flash  = 1'b1;
        st_next.erase_eeprom = !st_reg.sys.eeprom_preserve || locked;
      end
      // writes to fuse indices fall through with no effect
    end

    if (sys_rst) begin
      st_next          = '0;
      st_next.phase    = ST_HOLD;
      st_next.por_seen = power_on_reset;
      // timer fault settings survive any reset but power-on
      if (!power_on_reset) begin
        st_next.tmr = st_reg.tmr;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge clk) begin
    st_reg <= st_next;
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign prdata              = st_reg.rdata;
  assign pready              = st_reg.ready;
  assign pslverr             = st_reg.slverr;
  assign fuse_rd_en          = st_reg.rd_en;
  assign fuse_rd_addr        = st_reg.rd_addr;
  assign crc_boot_req        = st_reg.boot_req;
  assign crc_app_req         = st_reg.app_req;
  assign watchdog_control_a  = st_reg.wdt;
  assign brownout_control    = st_reg.bod;
  assign osc_calibration     = st_reg.osc;
  assign timer_fault_control = st_reg.tmr;
  assign system_control      = st_reg.sys;
  assign reset_released      = st_reg.released;
  assign compare_force       = st_reg.force_cmp;
  assign flash_erase         = st_reg.erase_flash;
  assign eeprom_erase        = st_reg.erase_eeprom;

endmodule

// >>> hdl/fuse_config_loader_regs.svh
// register indices, field positions and constants of the fuse configuration loader
//
// Function
// - at reset copy fuse watchdog bits 7:4 into the watchdog window field
// - at reset copy fuse watchdog bits 3:0 into the watchdog period field
// - at reset copy brown-out bits 7:5 into the threshold field, eight ascending levels
// - at reset copy brown-out sample-rate bit: zero 1kHz, one 125Hz
// - at reset load active/idle brown-out mode bits 3:2, four codes
// - at reset load sleep brown-out mode bits 1:0, code three reserved
// - at reset copy oscillator lock bit 7 into calibration lock bit
// - frequency select picks 16MHz or 20MHz and matching factory calibration values
// - at start-up copy each timer fault fuse bit into timer fault control
// - timer compare settings reload only after power-on reset, else stay untouched
// - compare enable bits 7:4 enable each compare output on its pin
// - compare default bits 3:0 set level after reset and on debug entry while the fault detect flag is set
// - boot check disable bit 7 zero runs boot CRC before reset release
// - app check disable bit 6 zero runs application CRC before reset release
// - targets written at end of start-up; fuse changes act only after reset
// - reset pin function field selects general I/O, external reset or programming
// - eeprom preserve keeps EEPROM on chip erase unless device is locked
`ifndef FUSE_CONFIG_LOADER_REGS_SVH
`define FUSE_CONFIG_LOADER_REGS_SVH

// register indices, byte address is four times the index
`define IDX_WATCHDOG      4'h0
`define IDX_BROWNOUT      4'h1
`define IDX_OSCILLATOR    4'h2
`define IDX_TIMER_FAULT   4'h4
`define IDX_SYSTEM_CFG0   4'h5
`define IDX_SYSTEM_CFG1   4'h6
`define IDX_APP_END       4'h7
`define IDX_BOOT_END      4'h8
`define IDX_DEVICE_LOCK   4'ha
`define IDX_FIRST_FUSE    4'h0
`define IDX_LAST_FUSE     4'ha
`define IDX_LOADER_STATUS 4'hb
`define IDX_ERASE_CONTROL 4'hc

// apb address fields
`define APB_IDX  5:2
`define APB_TOP  7:6
`define APB_LANE 1:0

// fuse field positions
`define WDT_WINDOW    7:4
`define WDT_PERIOD    3:0
`define BOD_LEVEL     7:5
`define BOD_SAMPLE    4
`define BOD_ACTIVE    3:2
`define BOD_SLEEP     1:0
`define OSC_LOCK      7
`define OSC_FREQ      1:0
`define TMR_ENABLE    7:4
`define TMR_LEVEL     3:0
`define CFG0_BOOT_DIS 7
`define CFG0_APP_DIS  6
`define CFG0_RST_PIN  3:2
`define CFG0_EE_SAVE  0

// codes
`define FREQ_16MHZ     2'h1
`define FREQ_20MHZ     2'h2
`define SLEEP_RESERVED 2'h3
`define LOCK_OPEN      8'hc5
`define ERASE_GO_BIT   0

// loader status bits
`define STAT_RELEASED  0
`define STAT_FAILED    1
`define STAT_POR       2
`define STAT_OSC16     3
`define STAT_FREQ_RSV  4
`define STAT_SLEEP_RSV 5
`define STAT_BOOT_CHK  6
`define STAT_APP_CHK   7

`endif

// >>> hdl/fuse_config_pkg.sv
// types of the fuse configuration loader
package fuse_config_pkg;

  typedef enum logic [7:0] {
    ST_HOLD  = 8'h01,
    ST_READ  = 8'h02,
    ST_CAPT  = 8'h04,
    ST_APPLY = 8'h08,
    ST_CHECK = 8'h10,
    ST_WAIT  = 8'h20,
    ST_RUN   = 8'h40,
    ST_FAIL  = 8'h80
  } phase_t;

  typedef struct packed {
    logic [3:0] window;
    logic [3:0] period;
  } watchdog_ctrl_t;

  typedef struct packed {
    logic [2:0] threshold;
    logic       sample_rate;
    logic [1:0] active_mode;
    logic [1:0] sleep_mode;
  } brownout_ctrl_t;

  typedef struct packed {
    logic       run_16mhz;
    logic [7:0] trim;
    logic       lock;
    logic [3:0] temp_trim;
  } osc_ctrl_t;

  typedef struct packed {
    logic [3:0] output_enable;
    logic [3:0] default_level;
  } timer_fault_t;

  typedef struct packed {
    logic [1:0] reset_pin_function;
    logic       eeprom_preserve;
    logic       boot_check_disable;
    logic       app_check_disable;
  } sys_ctrl_t;

  typedef struct packed {
    logic [7:0] trim16;
    logic [3:0] temp16;
    logic [7:0] trim20;
    logic [3:0] temp20;
  } factory_cal_t;

endpackage

// >>> testbench/fuse_config_loader_checker.sv
// assertions on the fuse configuration loader ports
`timescale 1ns/1ns
module fuse_config_loader_checker
  import fuse_config_pkg::*;
(
  // clock and reset
  input wire logic           clk,
  input wire logic           sys_rst,
  input wire logic           power_on_reset,
  // fuse read
  input wire logic           fuse_rd_en,
  input wire logic [3:0]     fuse_rd_addr,
  input wire logic [7:0]     fuse_rd_data,
  // crc
  input wire logic           crc_boot_req,
  input wire logic           crc_app_req,
  input wire logic           crc_done,
  input wire logic           crc_ok,
  // targets
  input wire watchdog_ctrl_t watchdog_control_a,
  input wire brownout_ctrl_t brownout_control,
  input wire osc_ctrl_t      osc_calibration,
  input wire timer_fault_t   timer_fault_control,
  input wire sys_ctrl_t      system_control,
  input wire logic           reset_released,
  input wire logic           flash_erase,
  input wire logic           eeprom_erase,
  // debug
  input wire logic           debug_entry,
  input wire logic           fault_detect_flag,
  input wire logic           compare_force
);
  logic [7:0] cap [0:10];
  logic       por_seen;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////
  // fuse bytes as read, and cause of last reset
  always_ff @(posedge clk) begin
    if (fuse_rd_en)
      cap[fuse_rd_addr] <= fuse_rd_data;
    if (sys_rst)
      por_seen <= power_on_reset;
  end
  ////////////////////////////////////////
  a_wdt_loaded: assert property ($rose(reset_released) |-> watchdog_control_a == cap[0])
    else $error("watchdog control differs from fuse");
  a_bod_loaded: assert property ($rose(reset_released) |-> brownout_control == cap[1])
    else $error("brownout control differs from fuse");
  a_osc_lock: assert property ($rose(reset_released) |-> osc_calibration.lock == cap[2][7])
    else $error("oscillator lock differs from fuse");
  a_osc_freq: assert property ($rose(reset_released) |->
    osc_calibration.run_16mhz == (cap[2][1:0] == 2'h1))
    else $error("frequency select wrong");
  a_tmr_por: assert property ($rose(reset_released) && por_seen |-> timer_fault_control == cap[4])
    else $error("timer fault control not loaded");
  a_tmr_keep: assert property (!por_seen |-> $stable(timer_fault_control))
    else $error("timer fault control changed without power-on");
  a_boot_req: assert property (crc_boot_req |-> !cap[5][7])
    else $error("boot check requested while disabled");
  a_app_req: assert property (crc_app_req |-> !cap[5][6])
    else $error("app check requested while disabled");
  a_release_gate: assert property ($rose(reset_released) |->
    ($past(crc_done) && $past(crc_ok)) || (cap[5][7] && cap[5][6]))
    else $error("released without passing check");
  a_hold_steady: assert property (reset_released |=>
    $stable({watchdog_control_a, brownout_control, osc_calibration, system_control}))
    else $error("targets changed while running");
  a_erase_lock: assert property (flash_erase |->
    eeprom_erase == (!cap[5][0] || cap[10] != 8'hc5))
    else $error("eeprom erase decision wrong");
  a_pin_func: assert property ($rose(reset_released) |->
    system_control.reset_pin_function == cap[5][3:2])
    else $error("reset pin function differs from fuse");
  a_debug_force: assert property (reset_released && debug_entry && fault_detect_flag
    |=> compare_force)
    else $error("compare default not forced on debug entry");
  a_force_cause: assert property (compare_force |->
    $past(debug_entry) && $past(fault_detect_flag))
    else $error("compare default forced without cause");
  c_release: cover property ($rose(reset_released));
  c_force: cover property (compare_force);
  c_crc: cover property (crc_done && crc_ok);
  c_erase: cover property (flash_erase);
endmodule

// >>> testbench/fuse_config_loader_tb.sv
// self-checking bench of the fuse configuration loader
`timescale 1ns/1ns
module fuse_config_loader_tb
  import fuse_config_pkg::*;
;
  logic clk = 0, sys_rst = 1, power_on_reset = 1, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, fuse_rd_en, crc_boot_req, crc_app_req, crc_done, crc_ok;
  logic [3:0] fuse_rd_addr;
  logic [7:0] fuse_rd_data;
  logic crc_pass = 1, reset_released, compare_force, flash_erase, eeprom_erase, fe, ee, err;
  logic debug_entry = 0, fault_detect_flag = 0;
  factory_cal_t factory_cal = {8'h5a, 4'h3, 8'hc6, 4'h9};
  watchdog_ctrl_t watchdog_control_a;
  brownout_ctrl_t brownout_control;
  osc_ctrl_t osc_calibration;
  timer_fault_t timer_fault_control;
  sys_ctrl_t system_control;
  int n_errors = 0, tests_run = 0, cyc = 0;
  fuse_config_loader dut (
    .clk                 (clk),
    .sys_rst             (sys_rst),
    .power_on_reset      (power_on_reset),
    .psel                (psel),
    .penable             (penable),
    .pwrite              (pwrite),
    .paddr               (paddr),
    .pwdata              (pwdata),
    .prdata              (prdata),
    .pready              (pready),
    .pslverr             (pslverr),
    .fuse_rd_en          (fuse_rd_en),
    .fuse_rd_addr        (fuse_rd_addr),
    .fuse_rd_data        (fuse_rd_data),
    .factory_cal         (factory_cal),
    .crc_boot_req        (crc_boot_req),
    .crc_app_req         (crc_app_req),
    .crc_done            (crc_done),
    .crc_ok              (crc_ok),
    .watchdog_control_a  (watchdog_control_a),
    .brownout_control    (brownout_control),
    .osc_calibration     (osc_calibration),
    .timer_fault_control (timer_fault_control),
    .system_control      (system_control),
    .reset_released      (reset_released),
    .debug_entry         (debug_entry),
    .fault_detect_flag   (fault_detect_flag),
    .compare_force       (compare_force),
    .flash_erase         (flash_erase),
    .eeprom_erase        (eeprom_erase)
  );
  fuse_storage_model fm (
    .clk          (clk),
    .fuse_rd_en   (fuse_rd_en),
    .fuse_rd_addr (fuse_rd_addr),
    .fuse_rd_data (fuse_rd_data),
    .crc_boot_req (crc_boot_req),
    .crc_app_req  (crc_app_req),
    .crc_pass     (crc_pass),
    .crc_done     (crc_done),
    .crc_ok       (crc_ok)
  );
  always #50 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      give_verdict;
    end
  end
  ////////////////////////////////////////
  task give_verdict;
    $display("errors %0d of %0d checks", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do
      @(posedge clk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    fe = flash_erase;
    ee = eeprom_erase;
    psel <= 0;
    penable <= 0;
    @(posedge clk);
  endtask
  task load(input logic por);
    sys_rst <= 1;
    power_on_reset <= por;
    repeat (6) @(posedge clk);
    sys_rst <= 0;
    power_on_reset <= 0;
    for (int k = 0; k < 100 && reset_released !== 1'b1; k++)
      @(posedge clk);
  endtask
  task targets(input logic [7:0] tf);
    logic f;
    f = fm.mem[2][1:0] == 2'h1;
    chk(reset_released, 1);
    chk(watchdog_control_a, fm.mem[0]);
    chk(brownout_control, fm.mem[1]);
    chk(osc_calibration, {f, f ? factory_cal.trim16 : factory_cal.trim20, fm.mem[2][7],
      f ? factory_cal.temp16 : factory_cal.temp20});
    chk(timer_fault_control, tf);
    chk(system_control, {fm.mem[5][3:2], fm.mem[5][0], fm.mem[5][7:6]});
  endtask
  ////////////////////////////////////////
  task sc_por_load;
    fm.mem = '{8'h7c, 8'h00, 8'h81, 8'h00, 8'ha5, 8'h04, 8'h00, 8'h10, 8'h08, 8'h00, 8'hc5};
    load(1);
    targets(8'ha5);
  endtask
  task sc_apb(input logic exp_ee);
    for (int i = 0; i < 11; i++) begin
      apb(0, 8'(4 * i), 0);
      chk(rd, {24'h0, fm.mem[i]});
    end
    apb(1, 8'h00, 32'hff);
    apb(0, 8'h00, 0);
    chk(rd, {24'h0, fm.mem[0]});
    chk(watchdog_control_a, fm.mem[0]);
    apb(0, 8'h34, 0);
    chk(err, 1);
    apb(1, 8'h30, 1);
    chk({fe, ee}, {1'b1, exp_ee});
  endtask
  task sc_warm;
    for (int i = 0; i < 4; i++) begin
      fm.mem[0] = 8'(8'h12 + i);
      fm.mem[1] = {3'(2 * i + 1), i[0], i[1:0], i[1:0]};
      fm.mem[2] = {i[0], 5'h0, i[1:0]};
      fm.mem[4] = 8'h3c;
      fm.mem[5] = 8'hc9;
      load(0);
      targets(8'ha5);
    end
  endtask
  task sc_crc_fail;
    fm.mem[5] = 8'h40;
    crc_pass <= 0;
    load(0);
    chk(reset_released, 0);
    apb(0, 8'h2c, 0);
    chk(rd[1], 1);
    crc_pass <= 1;
    load(1);
    targets(8'h3c);
  endtask
  task sc_debug;
    debug_entry <= 1;
    @(posedge clk);
    @(posedge clk);
    chk(compare_force, 0);
    fault_detect_flag <= 1;
    @(posedge clk);
    debug_entry <= 0;
    fault_detect_flag <= 0;
    @(posedge clk);
    chk(compare_force, 1);
    @(posedge clk);
    chk(compare_force, 0);
  endtask
  initial begin
    sc_por_load;
    sc_apb(1);
    sc_warm;
    sc_apb(0);
    sc_crc_fail;
    sc_debug;
    give_verdict;
  end
endmodule
bind fuse_config_loader fuse_config_loader_checker chk_i (
  .clk                 (clk),
  .sys_rst             (sys_rst),
  .power_on_reset      (power_on_reset),
  .fuse_rd_en          (fuse_rd_en),
  .fuse_rd_addr        (fuse_rd_addr),
  .fuse_rd_data        (fuse_rd_data),
  .crc_boot_req        (crc_boot_req),
  .crc_app_req         (crc_app_req),
  .crc_done            (crc_done),
  .crc_ok              (crc_ok),
  .watchdog_control_a  (watchdog_control_a),
  .brownout_control    (brownout_control),
  .osc_calibration     (osc_calibration),
  .timer_fault_control (timer_fault_control),
  .system_control      (system_control),
  .reset_released      (reset_released),
  .flash_erase         (flash_erase),
  .eeprom_erase        (eeprom_erase),
  .debug_entry         (debug_entry),
  .fault_detect_flag   (fault_detect_flag),
  .compare_force       (compare_force)
);

// >>> testbench/fuse_storage_model.sv
// fuse storage and crc unit model
`timescale 1ns/1ns
module fuse_storage_model (
  // clock
  input  wire logic       clk,
  // fuse read port
  input  wire logic       fuse_rd_en,
  input  wire logic [3:0] fuse_rd_addr,
  output logic      [7:0] fuse_rd_data,
  // crc unit
  input  wire logic       crc_boot_req,
  input  wire logic       crc_app_req,
  input  wire logic       crc_pass,
  output logic            crc_done,
  output logic            crc_ok
);
  logic [7:0] mem [0:10];
  int         cnt = 0;
  ////////////////////////////////////////
  // byte only valid while strobed, inverted otherwise
  assign fuse_rd_data = fuse_rd_en ? mem[fuse_rd_addr] : ~mem[fuse_rd_addr];
  assign crc_ok = crc_done ? crc_pass : ~crc_pass;
  initial crc_done = 1'b0;
  // scan takes a few cycles, one done covers both sections
  always @(posedge clk) begin
    crc_done <= 1'b0;
    if ((crc_boot_req || crc_app_req) && !crc_done) begin
      cnt <= cnt + 1;
      if (cnt == 5) begin
        crc_done <= 1'b1;
        cnt <= 0;
      end
    end
  end
endmodule
